// ### dpr_pkg.sv
// Purpose: Shared constants for the paged acquisition register window.
// Assumes: Byte-wide host I/O bus, one clock.
// Notes: Offsets are the low four address bits within the window.
package dpr_pkg;
	typedef logic [1:0] dpr_page_t;
	typedef logic [3:0] dpr_off_t;

	localparam logic [15:0] DPR_BASE_DEFAULT = 16'h0280;
	localparam int DPR_OFF_BITS = 4;
	localparam int DPR_ADDR_BITS = 16;

	localparam dpr_off_t OFF_CMD = 4'h0;
	localparam dpr_off_t OFF_ENH = 4'h1;
	localparam dpr_off_t OFF_CHAN = 4'h2;
	localparam dpr_off_t OFF_GAIN = 4'h3;
	localparam dpr_off_t OFF_IRQ = 4'h4;
	localparam dpr_off_t OFF_THR = 4'h5;
	localparam dpr_off_t OFF_OUT_LO = 4'h6;
	localparam dpr_off_t OFF_OUT_HI = 4'h7;
	localparam dpr_off_t OFF_PORT_A = 4'h8;
	localparam dpr_off_t OFF_PORT_B = 4'h9;
	localparam dpr_off_t OFF_PORT_C = 4'ha;
	localparam dpr_off_t OFF_PORT_DIR = 4'hb;
	localparam dpr_off_t OFF_PG_C = 4'hc;
	localparam dpr_off_t OFF_PG_D = 4'hd;
	localparam dpr_off_t OFF_PG_E = 4'he;
	localparam dpr_off_t OFF_PG_F = 4'hf;

	localparam dpr_page_t PAGE_0 = 2'h0;
	localparam dpr_page_t PAGE_1 = 2'h1;
	localparam dpr_page_t PAGE_2 = 2'h2;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] CHECK_PAGE1 = 8'ha1;
	localparam logic [7:0] CHECK_PAGE2 = 8'ha2;
	localparam logic [7:0] COMPAT_KEEP_A = 8'ha5;
	localparam logic [7:0] COMPAT_KEEP_B = 8'ha6;

	// Field positions
	localparam int CMD_BOARD_CLR_BIT = 6;
	localparam int GAIN_PAGE_LSB = 4;
	localparam int GAIN_SCAN_BIT = 2;
	localparam int IRQ_DMA_BIT = 3;
	localparam int OUT_CHAN_LSB = 6;
	localparam int DIR_UNUSED_BIT = 6;
	localparam logic [7:0] IRQ_WR_MASK = 8'hf7;
	localparam logic [7:0] DIR_WR_MASK = 8'hbb;
	localparam logic [7:0] POL_WR_MASK = 8'h3f;
	localparam logic [7:0] BIT0_MASK = 8'h01;
	localparam logic [7:0] CAL_STAT_MASK = 8'h70;
endpackage : dpr_pkg

// ### dpr_bus_if.sv
// Purpose: Decoded host access shared between the window modules.
// Assumes: Strobes are one-cycle pulses on core_clk.
// Notes: Filled by the address decoder, read by page control and top.
`timescale 1ns/1ps
interface dpr_bus_if;
	import dpr_pkg::*;
	logic hit;
	logic wr;
	logic rd;
	dpr_off_t off;
	logic [7:0] wdata;
	modport source (output hit, output wr, output rd, output off, output wdata);
	modport sink (input hit, input wr, input rd, input off, input wdata);
endinterface : dpr_bus_if

// ### dpr_addr_decode.sv
// Purpose: Match the host I/O address against the window base.
// Assumes: Host strobes and address are synchronous to core_clk.
// Notes: Purely combinational; a disabled block sees no hit at all.
`timescale 1ns/1ps
module dpr_addr_decode import dpr_pkg::*; #(
	parameter logic [DPR_ADDR_BITS-1:0] BASE_ADDR = DPR_BASE_DEFAULT
) (
	input wire logic [DPR_ADDR_BITS-1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic daq_enable,
	dpr_bus_if.source bus
);
	wire base_match;

	assign base_match = io_addr[DPR_ADDR_BITS-1:DPR_OFF_BITS]
		== BASE_ADDR[DPR_ADDR_BITS-1:DPR_OFF_BITS];
	assign bus.hit = base_match & daq_enable;
	assign bus.off = io_addr[DPR_OFF_BITS-1:0];
	assign bus.wr = io_wr & bus.hit;
	assign bus.rd = io_rd & bus.hit;
	assign bus.wdata = io_wdata;
endmodule : dpr_addr_decode

// ### dpr_page_ctrl.sv
// Purpose: Hold the page select and derive the active page.
// Assumes: Board clear arrives as a one-cycle pulse.
// Notes: The stored select survives a drop out of enhanced mode.
`timescale 1ns/1ps
module dpr_page_ctrl import dpr_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	dpr_bus_if.sink bus,
	input wire logic enhanced_mode,
	input wire logic board_clear,
	output dpr_page_t page_sel,
	output dpr_page_t active_page
);
	dpr_page_t page_r;
	dpr_page_t page_nxt;
	wire enh_wr;
	wire enh_keep;
	wire gain_wr;

	assign enh_wr = bus.wr & (bus.off == OFF_ENH);
	assign enh_keep = (bus.wdata == COMPAT_KEEP_A) | (bus.wdata == COMPAT_KEEP_B);
	assign gain_wr = bus.wr & (bus.off == OFF_GAIN);
	assign page_nxt = board_clear ? PAGE_0 :
		gain_wr ? bus.wdata[GAIN_PAGE_LSB+1:GAIN_PAGE_LSB] :
		(enh_wr & ~enh_keep) ? bus.wdata[1:0] : page_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			page_r <= PAGE_0;
		end else begin
			page_r <= page_nxt;
		end
	end

	assign page_sel = page_r;
	assign active_page = enhanced_mode ? page_r : PAGE_0;
endmodule : dpr_page_ctrl

// ### dpr_register_map.sv
// Contract
// - Decode sixteen byte addresses, default base 280h through 28Fh.
// - While acquisition is disabled, ignore every host read and write.
// - Three pages, chosen by offset 3 page bits in enhanced mode.
// - Offsets 0 to 11 always page 0; only 12 to 15 paged.
// - Unused bits ignore writes and read as zero.
// - Offset 3 writes page, scan, gain; reads status, scan, gain.
// - Page 1 offset 15 reads constant A1 hex.
// - Page 2 offset 15 reads constant A2 hex.
// - Output value low byte at 6; top nibble and channel at 7.
// - Page 1 offset 12 writes trim or cal data, reads cal data.
// - Offset 0 write bits are independent one-shot triggers.
// - Offset 1 carries page copy; A5 and A6 leave page unchanged.
// - Standard mode keeps page 0 regardless of page bits.
//
// Purpose: Paged register window of the acquisition block.
// Assumes: Host strobes are one-cycle pulses on core_clk.
// Notes: Read data lands one cycle after the read strobe.
`timescale 1ns/1ps
module dpr_register_map import dpr_pkg::*; #(
	parameter logic [DPR_ADDR_BITS-1:0] BASE_ADDR = DPR_BASE_DEFAULT,
	// Arbitrary value, not a real part code
	parameter logic [7:0] REVISION_CODE = 8'h10
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [DPR_ADDR_BITS-1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic daq_enable,
	input wire logic enhanced_mode,
	input wire logic [15:0] sample_data,
	input wire logic [4:0] conv_status,
	input wire logic dma_active,
	input wire logic [7:0] fifo_depth,
	input wire logic [7:0] analog_status,
	input wire logic [7:0] calmem_rdata,
	input wire logic [7:0] cal_status,
	output logic [7:0] io_rdata,
	output logic io_rd_ack,
	output logic [7:0] cmd_pulse,
	output logic [7:0] chan_range,
	output logic scan_enable_bit,
	output logic [1:0] gain_code,
	output dpr_page_t active_page,
	output logic [7:0] irq_ctrl,
	output logic [7:0] fifo_threshold,
	output logic [11:0] output_value,
	output logic [1:0] output_channel,
	output logic output_load,
	output logic [31:0] port_regs,
	output logic [23:0] counter_value,
	output logic counter_ctrl_load,
	output logic [3:0] page1_wr_strobe,
	output logic [7:0] page_wr_data,
	output logic expanded_fifo,
	output logic [5:0] converter_polarity,
	output logic scan_int,
	output logic indicator_light
);
	dpr_bus_if bus ();
	dpr_page_t page_act;
	logic [7:0] rdata_r;
	logic rd_ack_r;
	logic [7:0] cmd_r;
	logic [7:0] chan_r;
	logic scan_r;
	logic [1:0] gain_r;
	dpr_page_t act_r;
	logic [7:0] irq_r;
	logic [7:0] thr_r;
	logic [7:0] out_lo_r;
	logic [11:0] out_val_r;
	logic [1:0] out_ch_r;
	logic out_load_r;
	logic [7:0] port_r [0:3];
	logic [7:0] ctr_r [0:2];
	logic ctr_ld_r;
	logic [3:0] p1_stb_r;
	logic [7:0] pwd_r;
	logic [7:0] calcmd_r;
	logic exfifo_r;
	logic [5:0] pol_r;
	logic scanint_r;
	logic led_r;

	wire wr;
	wire [7:0] wd;
	wire low_off;
	wire pg0;
	wire pg1;
	wire pg2;
	wire clr;
	wire [15:0] wsel;
	wire [7:0] low_rd [0:11];
	wire [7:0] hi_rd_p0;
	wire [7:0] hi_rd_p1;
	wire [7:0] hi_rd_p2;
	wire [7:0] hi_rd;
	wire [7:0] rd_mux;
	wire [11:0] out_val_nxt;
	dpr_addr_decode #(.BASE_ADDR(BASE_ADDR)) u_dec (
		.io_addr(io_addr),
		.io_wr(io_wr),
		.io_rd(io_rd),
		.io_wdata(io_wdata),
		.daq_enable(daq_enable),
		.bus(bus)
	);

	dpr_page_ctrl u_page (
		.core_clk(core_clk),
		.resetn(resetn),
		.bus(bus),
		.enhanced_mode(enhanced_mode),
		.board_clear(clr),
		.page_sel(),
		.active_page(page_act)
	);

	assign wr = bus.wr;
	assign wd = bus.wdata;
	assign low_off = bus.off < OFF_PG_C;
	assign pg0 = page_act == PAGE_0;
	assign pg1 = page_act == PAGE_1;
	assign pg2 = page_act == PAGE_2;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_wsel
			assign wsel[gi] = wr & (bus.off == dpr_off_t'(gi));
		end
	endgenerate

	assign clr = wsel[OFF_CMD] & wd[CMD_BOARD_CLR_BIT];
	assign out_val_nxt = {wd[3:0], out_lo_r};

	assign low_rd[0] = sample_data[7:0];
	assign low_rd[1] = sample_data[15:8];
	assign low_rd[2] = chan_r;
	assign low_rd[3] = {conv_status, scan_r, gain_r};
	assign low_rd[4] = {irq_r[7:4], dma_active, irq_r[2:0]};
	assign low_rd[5] = thr_r;
	assign low_rd[6] = fifo_depth;
	assign low_rd[7] = analog_status;
	assign low_rd[8] = port_r[0];
	assign low_rd[9] = port_r[1];
	assign low_rd[10] = port_r[2];
	assign low_rd[11] = port_r[3];

	assign hi_rd_p0 = (bus.off == OFF_PG_F) ? REVISION_CODE : ctr_r[bus.off[1:0]];
	// page 1 offset 12 reads cal data
	assign hi_rd_p1 = (bus.off == OFF_PG_C) ? calmem_rdata :
		(bus.off == OFF_PG_D) ? calcmd_r :
		(bus.off == OFF_PG_E) ? (cal_status & CAL_STAT_MASK) : CHECK_PAGE1;
	assign hi_rd_p2 = (bus.off == OFF_PG_C) ? {7'h00, exfifo_r} :
		(bus.off == OFF_PG_D) ? {2'h0, pol_r} :
		(bus.off == OFF_PG_E) ? {7'h00, scanint_r} : CHECK_PAGE2;
	// A select of 3 maps to no page and reads zero
	assign hi_rd = pg0 ? hi_rd_p0 : pg1 ? hi_rd_p1 : pg2 ? hi_rd_p2 : BYTE_ZERO;
	assign rd_mux = low_off ? low_rd[bus.off] : hi_rd;

	// Read return, registered so io_rdata is glitch free
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_r <= BYTE_ZERO;
			rd_ack_r <= 1'b0;
		end else begin
			rd_ack_r <= bus.rd;
			rdata_r <= bus.rd ? rd_mux : BYTE_ZERO;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cmd_r <= BYTE_ZERO;
		end else begin
			cmd_r <= wsel[OFF_CMD] ? wd : BYTE_ZERO;
		end
	end

	// Page 0 low registers; board clear spares the output converter
	always_ff @(posedge core_clk) begin
		if (!resetn || clr) begin
			chan_r <= BYTE_ZERO;
			scan_r <= 1'b0;
			gain_r <= 2'h0;
			irq_r <= BYTE_ZERO;
			thr_r <= BYTE_ZERO;
		end else begin
			if (wsel[OFF_CHAN]) begin
				chan_r <= wd;
			end
			if (wsel[OFF_GAIN]) begin
				scan_r <= wd[GAIN_SCAN_BIT];
				gain_r <= wd[1:0];
			end
			if (wsel[OFF_IRQ]) begin
				irq_r <= wd & IRQ_WR_MASK;
			end
			if (wsel[OFF_THR]) begin
				thr_r <= wd;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			out_lo_r <= BYTE_ZERO;
			out_val_r <= 12'h000;
			out_ch_r <= 2'h0;
			out_load_r <= 1'b0;
		end else begin
			out_load_r <= wsel[OFF_OUT_HI];
			if (wsel[OFF_OUT_LO]) begin
				out_lo_r <= wd;
			end
			if (wsel[OFF_OUT_HI]) begin
				out_val_r <= out_val_nxt;
				out_ch_r <= wd[OUT_CHAN_LSB+1:OUT_CHAN_LSB];
			end
		end
	end

	// Digital port registers, one per offset 8 to 11
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			always_ff @(posedge core_clk) begin
				if (!resetn || clr) begin
					port_r[gi] <= BYTE_ZERO;
				end else if (wsel[OFF_PORT_A + dpr_off_t'(gi)]) begin
					port_r[gi] <= (gi == 3) ? (wd & DIR_WR_MASK) : wd;
				end
			end
		end
	endgenerate

	// Page 0 counter bytes at offsets 12 to 14
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ctr
			always_ff @(posedge core_clk) begin
				if (!resetn || clr) begin
					ctr_r[gi] <= BYTE_ZERO;
				end else if (pg0 && wsel[OFF_PG_C + dpr_off_t'(gi)]) begin
					ctr_r[gi] <= wd;
				end
			end
		end
	endgenerate

	// page 1 writes and the page 0 offset 15 write go out as strobes
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctr_ld_r <= 1'b0;
			p1_stb_r <= 4'h0;
			pwd_r <= BYTE_ZERO;
		end else begin
			ctr_ld_r <= pg0 & wsel[OFF_PG_F];
			p1_stb_r <= pg1 ? wsel[OFF_PG_F:OFF_PG_C] : 4'h0;
			if (wr && !low_off) begin
				pwd_r <= wd;
			end
		end
	end

	// Page 1 and page 2 stored fields
	always_ff @(posedge core_clk) begin
		if (!resetn || clr) begin
			calcmd_r <= BYTE_ZERO;
			exfifo_r <= 1'b0;
			pol_r <= 6'h00;
			scanint_r <= 1'b0;
			led_r <= 1'b0;
		end else begin
			if (pg1 && wsel[OFF_PG_D]) begin
				calcmd_r <= wd;
			end
			if (pg2 && wsel[OFF_PG_C]) begin
				exfifo_r <= wd[0];
			end
			if (pg2 && wsel[OFF_PG_D]) begin
				pol_r <= wd[5:0];
			end
			if (pg2 && wsel[OFF_PG_E]) begin
				scanint_r <= wd[0];
			end
			if (pg2 && wsel[OFF_PG_F]) begin
				led_r <= wd[7];
			end
		end
	end

	// Active page mirrored through a flop for the output pin
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			act_r <= PAGE_0;
		end else begin
			act_r <= page_act;
		end
	end

	assign io_rdata = rdata_r;
	assign io_rd_ack = rd_ack_r;
	assign cmd_pulse = cmd_r;
	assign chan_range = chan_r;
	assign scan_enable_bit = scan_r;
	assign gain_code = gain_r;
	assign active_page = act_r;
	assign irq_ctrl = irq_r;
	assign fifo_threshold = thr_r;
	assign output_value = out_val_r;
	assign output_channel = out_ch_r;
	assign output_load = out_load_r;
	assign port_regs = {port_r[3], port_r[2], port_r[1], port_r[0]};
	assign counter_value = {ctr_r[2], ctr_r[1], ctr_r[0]};
	assign counter_ctrl_load = ctr_ld_r;
	assign page1_wr_strobe = p1_stb_r;
	assign page_wr_data = pwd_r;
	assign expanded_fifo = exfifo_r;
	assign converter_polarity = pol_r;
	assign scan_int = scanint_r;
	assign indicator_light = led_r;
endmodule : dpr_register_map

// ### dpr_register_map_props.sv
// Purpose: Port-level checks of the paged register window.
// Assumes: One clock, synchronous active-low reset.
// Notes: Page checks use the registered page of the cycle after the read.
`timescale 1ns/1ps
module dpr_register_map_props import dpr_pkg::*; #(
	parameter logic [DPR_ADDR_BITS-1:0] BASE_ADDR = DPR_BASE_DEFAULT
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [DPR_ADDR_BITS-1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic daq_enable,
	input wire logic enhanced_mode,
	input wire logic [4:0] conv_status,
	input wire logic [7:0] io_rdata,
	input wire logic io_rd_ack,
	input wire logic [7:0] cmd_pulse,
	input wire logic scan_enable_bit,
	input wire logic [1:0] gain_code,
	input wire dpr_page_t active_page,
	input wire logic [11:0] output_value,
	input wire logic [1:0] output_channel,
	input wire logic output_load
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire in_win = io_addr[15:4] == BASE_ADDR[15:4];
	wire rd_hit = daq_enable && in_win && io_rd;
	wire wr_hit = daq_enable && in_win && io_wr;
	wire [3:0] off = io_addr[3:0];
	read_answer_a: assert property (rd_hit |=> io_rd_ack)
		else $error("read not answered");
	disabled_quiet_a: assert property (io_rd && !daq_enable |=> !io_rd_ack && io_rdata == 8'h00)
		else $error("disabled read answered");
	outside_quiet_a: assert property (io_rd && !in_win |=> !io_rd_ack && io_rdata == 8'h00)
		else $error("outside read answered");
	gain_read_a: assert property (rd_hit && off == OFF_GAIN && !io_wr
		|=> io_rdata == {$past(conv_status), scan_enable_bit, gain_code})
		else $error("gain status read wrong");
	page1_check_a: assert property (rd_hit && off == OFF_PG_F ##1 active_page == PAGE_1
		|-> io_rdata == CHECK_PAGE1)
		else $error("page 1 check wrong");
	page2_check_a: assert property (rd_hit && off == OFF_PG_F ##1 active_page == PAGE_2
		|-> io_rdata == CHECK_PAGE2)
		else $error("page 2 check wrong");
	std_page_a: assert property (!enhanced_mode |=> active_page == PAGE_0)
		else $error("page left 0 in standard mode");
	cmd_once_a: assert property (1'b1
		|=> cmd_pulse == ($past(wr_hit && off == OFF_CMD) ? $past(io_wdata) : 8'h00))
		else $error("command pulse wrong");
	output_load_a: assert property (wr_hit && off == OFF_OUT_HI |=> output_load
		&& output_value[11:8] == $past(io_wdata[3:0]) && output_channel == $past(io_wdata[7:6]))
		else $error("output value load wrong");
	compat_keep_a: assert property (wr_hit && off == OFF_ENH && enhanced_mode
		&& (io_wdata == COMPAT_KEEP_A || io_wdata == COMPAT_KEEP_B) ##1 enhanced_mode
		|=> $stable(active_page))
		else $error("compat write moved page");
endmodule : dpr_register_map_props

bind dpr_register_map dpr_register_map_props #(.BASE_ADDR(BASE_ADDR)) i_dpr_register_map_props (.*);

// ### dpr_host_model.sv
// Purpose: Host processor on the I/O bus.
// Assumes: Strobes change at the falling edge.
// Notes: Released lines carry inverted values, never stale ones.
`timescale 1ns/1ps
module dpr_host_model (
	input wire logic core_clk,
	input wire logic io_rd_ack,
	input wire logic [7:0] io_rdata,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] dat);
		@(negedge core_clk);
		io_addr = a;
		io_wdata = dat;
		io_wr = 1'b1;
		@(negedge core_clk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~dat;
	endtask : wr
	// Bounded wait; no answer returns ack low
	task automatic rd(input logic [15:0] a, output logic [7:0] dat, output logic ack);
		@(negedge core_clk);
		io_addr = a;
		io_rd = 1'b1;
		ack = 1'b0;
		dat = 8'h00;
		// Answer stands one cycle only, so look at every falling edge
		for (int n = 0; n < 3 && ack !== 1'b1; n++) begin
			@(negedge core_clk);
			io_rd = 1'b0;
			io_addr = ~a;
			ack = io_rd_ack;
			dat = io_rdata;
		end
	endtask : rd
endmodule : dpr_host_model

// ### testbench.sv
// Purpose: Self-checking bench of the paged register window.
// Assumes: Host model drives the I/O bus.
// Notes: Status inputs change only between accesses.
`timescale 1ns/1ps
module testbench import dpr_pkg::*; ;
	localparam logic [15:0] BASE = DPR_BASE_DEFAULT;
	// Arbitrary revision value
	localparam logic [7:0] REV = 8'h3c;
	logic core_clk = 1'b0, resetn = 1'b0, daq_enable = 1'b1, enhanced_mode = 1'b0;
	logic dma_active = 1'b0;
	logic [15:0] sample_data = 16'h0000, io_addr;
	logic [4:0] conv_status = 5'h00;
	logic [7:0] fifo_depth = 8'h00, analog_status = 8'h00, calmem_rdata = 8'h00;
	logic [7:0] cal_status = 8'h00, io_wdata, io_rdata, cmd_pulse, chan_range, d, e, v;
	logic io_wr, io_rd, io_rd_ack, scan_enable_bit, output_load, ack;
	logic [1:0] gain_code, output_channel;
	dpr_page_t active_page;
	logic [11:0] output_value;
	logic [3:0] page1_wr_strobe;
	logic [7:0] irq_ctrl, fifo_threshold, page_wr_data;
	logic [31:0] port_regs;
	logic [23:0] counter_value;
	logic [5:0] converter_polarity;
	logic counter_ctrl_load, expanded_fifo, scan_int, indicator_light;
	logic [31:0] seed = 32'h24f3;
	int err_total = 0, total_checks = 0;
	dpr_host_model i_dpr_host_model (.core_clk(core_clk), .io_rd_ack(io_rd_ack),
		.io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
	dpr_register_map #(.REVISION_CODE(REV)) i_dpr_register_map (.core_clk(core_clk),
		.resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.daq_enable(daq_enable), .enhanced_mode(enhanced_mode), .sample_data(sample_data),
		.conv_status(conv_status), .dma_active(dma_active), .fifo_depth(fifo_depth),
		.analog_status(analog_status), .calmem_rdata(calmem_rdata), .cal_status(cal_status),
		.io_rdata(io_rdata), .io_rd_ack(io_rd_ack), .cmd_pulse(cmd_pulse),
		.chan_range(chan_range), .scan_enable_bit(scan_enable_bit), .gain_code(gain_code),
		.active_page(active_page), .irq_ctrl(irq_ctrl), .fifo_threshold(fifo_threshold),
		.output_value(output_value), .output_channel(output_channel),
		.output_load(output_load), .port_regs(port_regs), .counter_value(counter_value),
		.counter_ctrl_load(counter_ctrl_load), .page1_wr_strobe(page1_wr_strobe),
		.page_wr_data(page_wr_data), .expanded_fifo(expanded_fifo),
		.converter_polarity(converter_polarity), .scan_int(scan_int),
		.indicator_light(indicator_light));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [7:0] page_check(input int p);
		return p == 1 ? CHECK_PAGE1 : (p == 2 ? CHECK_PAGE2 : REV);
	endfunction : page_check
	function automatic logic [7:0] gain_read(input logic [4:0] st, input logic [7:0] w);
		return {st, w[2:0]};
	endfunction : gain_read
	task shake();
		seed = xs(seed);
		{sample_data, conv_status, dma_active} = seed[21:0];
		{fifo_depth, analog_status, calmem_rdata, cal_status} = seed;
	endtask : shake
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Read that must be answered; a missing answer counts
	task rdv(input logic [15:0] a);
		i_dpr_host_model.rd(a, v, ack);
		chk("ack", ack, 1'b1);
	endtask : rdv
	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(negedge core_clk);
		resetn = 1'b1;
		// Board logic toggles the enable at run time
		daq_enable = 1'b0;
		i_dpr_host_model.wr(BASE + 16'h2, 8'h5a);
		i_dpr_host_model.rd(BASE + 16'h2, v, ack);
		chk("dis ack", ack, 1'b0);
		chk("dis chan", chan_range, 8'h00);
		daq_enable = 1'b1;
		i_dpr_host_model.wr(BASE ^ 16'h0010, 8'h5a);
		i_dpr_host_model.rd(BASE ^ 16'h0010, v, ack);
		chk("out chan", {ack, chan_range}, 9'h000);
		$display("done window");
		for (int i = 0; i < 8; i++) begin
			shake();
			d = seed[7:0];
			i_dpr_host_model.wr(BASE + 16'h2, d);
			chk("chan", chan_range, d);
			i_dpr_host_model.wr(BASE + 16'h3, d);
			rdv(BASE + 16'h3);
			chk("gain rd", v, gain_read(conv_status, d));
			chk("gain out", {scan_enable_bit, gain_code}, d[2:0]);
			rdv(BASE + 16'hf);
			chk("std page", v, REV);
		end
		$display("done gain");
		enhanced_mode = 1'b1;
		for (int p = 0; p < 3; p++) begin
			i_dpr_host_model.wr(BASE + 16'h3, {2'b00, p[1:0], 4'h0});
			rdv(BASE + 16'hf);
			chk("page chk", v, page_check(p));
			rdv(BASE + 16'h2);
			chk("low fixed", v, d);
		end
		i_dpr_host_model.wr(BASE + 16'h1, COMPAT_KEEP_A);
		i_dpr_host_model.wr(BASE + 16'h1, COMPAT_KEEP_B);
		chk("keep page", active_page, PAGE_2);
		i_dpr_host_model.wr(BASE + 16'h1, 8'h01);
		// Registered page shows one cycle after the write
		@(negedge core_clk);
		chk("copy page", active_page, PAGE_1);
		shake();
		rdv(BASE + 16'hc);
		chk("cal rd", v, calmem_rdata);
		i_dpr_host_model.wr(BASE + 16'hc, d);
		chk("cal wr", page1_wr_strobe, 4'h1);
		i_dpr_host_model.wr(BASE + 16'hd, d);
		rdv(BASE + 16'hd);
		chk("cal cmd", v, d);
		rdv(BASE + 16'he);
		chk("cal stat", v, cal_status & CAL_STAT_MASK);
		i_dpr_host_model.wr(BASE + 16'hf, d);
		chk("p1 data", {page1_wr_strobe, page_wr_data}, {4'h8, d});
		enhanced_mode = 1'b0;
		rdv(BASE + 16'hf);
		chk("std keep", v, REV);
		$display("done pages");
		e = seed[15:8];
		i_dpr_host_model.wr(BASE + 16'h6, d);
		i_dpr_host_model.wr(BASE + 16'h7, e);
		chk("out", {output_channel, output_load, output_value}, {e[7:6], 1'b1, e[3:0], d});
		for (int b = 0; b < 9; b++) begin
			v = b == 8 ? 8'hb5 : 8'h01 << b;
			i_dpr_host_model.wr(BASE, v);
			chk("cmd", cmd_pulse, v);
		end
		chk("clr chan", chan_range, 8'h00);
		chk("clr keep", output_value, {e[3:0], d});
		$display("done command");
		enhanced_mode = 1'b1;
		for (int i = 0; i < 4; i++) begin
			shake();
			d = seed[31:24];
			i_dpr_host_model.wr(BASE + 16'h4, d);
			rdv(BASE + 16'h4);
			chk("irq rd", v, {d[7:4], dma_active, d[2:0]});
			chk("irq out", irq_ctrl, d & IRQ_WR_MASK);
			i_dpr_host_model.wr(BASE + 16'h5, d);
			chk("thr", fifo_threshold, d);
			rdv(BASE + 16'h7);
			chk("ana", v, analog_status);
			i_dpr_host_model.wr(BASE + 16'hb, d);
			rdv(BASE + 16'hb);
			chk("dir", {v, port_regs[31:24]}, {2{d & DIR_WR_MASK}});
			i_dpr_host_model.wr(BASE + 16'h1, 8'h00);
			i_dpr_host_model.wr(BASE + 16'he, d);
			rdv(BASE + 16'he);
			chk("ctr", {v, counter_value[23:16]}, {d, d});
			i_dpr_host_model.wr(BASE + 16'hf, d);
			chk("ctr load", {counter_ctrl_load, page_wr_data}, {1'b1, d});
			i_dpr_host_model.wr(BASE + 16'h1, 8'h02);
			i_dpr_host_model.wr(BASE + 16'hd, d);
			rdv(BASE + 16'hd);
			chk("pol", {v, 2'b00, converter_polarity}, {2{d & POL_WR_MASK}});
			i_dpr_host_model.wr(BASE + 16'hc, d);
			i_dpr_host_model.wr(BASE + 16'he, ~d);
			i_dpr_host_model.wr(BASE + 16'hf, d);
			rdv(BASE + 16'he);
			chk("pg2 rd", v, ~d & BIT0_MASK);
			chk("pg2 out", {expanded_fifo, scan_int, indicator_light}, {d[0], ~d[0], d[7]});
			i_dpr_host_model.wr(BASE + 16'h1, 8'h03);
			rdv(BASE + 16'hf);
			chk("no page", v, BYTE_ZERO);
			rdv(BASE + 16'h1);
			chk("smp hi", v, sample_data[15:8]);
		end
		$display("done regs");
		resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		chk("rst", {output_value, output_channel, chan_range, active_page}, 24'h0);
		rdv(BASE + 16'h3);
		chk("rst gain", v[2:0], 3'h0);
		$display("done reset");
		report_and_stop();
	end
endmodule : testbench
